//--- src/far_line_perf_monitor.sv
// far-end line performance monitor: per-second classification and counters
// assumes rei_valid, rdi_defect, rfi_failure, tick, period_end are on clk
//
// What this block does
// - below OC-48 accept up to 8xN errors
// - at OC-48 accept 0 to 255 errors
// - add each reported error to violations
// - errored second: any error or RDI defect
// - severe second: errors reach K or RDI
// - ten severe seconds make line unavailable
// - ten non-severe seconds restore availability
// - count each RFI failure event once
// - boundary-spanning event counts only where started
`timescale 1ns/1ns
module far_line_perf_monitor #(
   parameter int sts_n = 48,
   parameter bit is_oc48 = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rei_valid,
   input wire logic [10:0] rei_count,
   input wire logic rdi_defect,
   input wire logic rfi_failure,
   input wire logic [23:0] severe_threshold,
   input wire logic tick,
   input wire logic period_end,
   output logic [31:0] far_line_coding_violation_count,
   output logic [31:0] far_line_errored_second_count,
   output logic [31:0] far_line_severe_second_count,
   output logic [31:0] far_line_unavailable_second_count,
   output logic [31:0] far_line_failure_event_count,
   output logic far_line_unavailable,
   output logic period_done
);
   localparam logic [10:0] rei_cap = is_oc48 ?
      11'(far_line_pkg::rei_max_oc48) : 11'(far_line_pkg::rei_per_sts * sts_n);

   far_line_if link ();
   far_line_avail u_avail (.clk(clk), .rst(rst), .link(link));

   logic [10:0] rei_ok;
   logic [23:0] sec_errors;
   logic sec_rdi;
   logic rfi_prev;
   logic rfi_start;
   logic [31:0] cv_acc, es_acc, ses_acc, uas_acc, fc_acc;
   logic sec_errored, sec_severe;

   // out-of-range indications are clamped to the line's legal maximum
   always_comb begin
      rei_ok = (rei_count > rei_cap) ? rei_cap : rei_count;
   end

   always_comb begin
      sec_errored = (sec_errors != 24'h0) || sec_rdi || rdi_defect;
      sec_severe = (sec_errors >= severe_threshold) || sec_rdi
         || rdi_defect;
   end

   assign link.second_done = tick;
   assign link.severe = sec_severe;
   assign far_line_unavailable = link.unavailable;

   // per-second error and defect collection, restarted on each tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sec_errors <= 24'h0;
         sec_rdi <= 1'b0;
      end else if (tick) begin
         sec_errors <= rei_valid ? 24'(rei_ok) : 24'h0;
         sec_rdi <= 1'b0;
      end else begin
         if (rei_valid)
            sec_errors <= sec_errors + 24'(rei_ok);
         if (rdi_defect)
            sec_rdi <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         rfi_prev <= 1'b0;
      else
         rfi_prev <= rfi_failure;
   end

   // an event is one rising edge, however long the failure stands
   assign rfi_start = rfi_failure && !rfi_prev;

   // counting only the rising edge keeps a spanning event in its first period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cv_acc <= far_line_pkg::count_reset;
         es_acc <= far_line_pkg::count_reset;
         ses_acc <= far_line_pkg::count_reset;
         uas_acc <= far_line_pkg::count_reset;
         fc_acc <= far_line_pkg::count_reset;
      end else if (period_end) begin
         cv_acc <= rei_valid ? 32'(rei_ok) : 32'h0;
         es_acc <= far_line_pkg::count_reset;
         ses_acc <= far_line_pkg::count_reset;
         uas_acc <= far_line_pkg::count_reset;
         fc_acc <= rfi_start ? 32'h1 : 32'h0;
      end else begin
         if (rei_valid)
            cv_acc <= cv_acc + 32'(rei_ok);
         if (rfi_start)
            fc_acc <= fc_acc + 32'h1;
         if (tick) begin
            if (sec_errored)
               es_acc <= es_acc + 32'h1;
            if (sec_severe)
               ses_acc <= ses_acc + 32'h1;
            if (link.unavailable)
               uas_acc <= uas_acc + 32'h1;
         end
      end
   end

   // published totals of the period just closed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         far_line_coding_violation_count <= far_line_pkg::count_reset;
         far_line_errored_second_count <= far_line_pkg::count_reset;
         far_line_severe_second_count <= far_line_pkg::count_reset;
         far_line_unavailable_second_count <= far_line_pkg::count_reset;
         far_line_failure_event_count <= far_line_pkg::count_reset;
         period_done <= 1'b0;
      end else begin
         period_done <= period_end;
         if (period_end) begin
            far_line_coding_violation_count <= cv_acc;
            far_line_errored_second_count <= es_acc;
            far_line_severe_second_count <= ses_acc;
            far_line_unavailable_second_count <= uas_acc;
            far_line_failure_event_count <= fc_acc;
         end
      end
   end

   property p_cv;
      @(posedge clk) disable iff (rst)
      (rei_valid && !period_end) |=>
         cv_acc == $past(cv_acc) + 32'($past(rei_ok));
   endproperty
   a_cv: assert property (p_cv) else $error("violation sum wrong");
   property p_clamp;
      @(posedge clk) disable iff (rst) rei_ok <= rei_cap;
   endproperty
   a_clamp: assert property (p_clamp) else $error("indication over cap");
   property p_cap48;
      @(posedge clk) disable iff (rst)
      is_oc48 |-> rei_ok <= 11'h0ff;
   endproperty
   a_cap48: assert property (p_cap48) else $error("oc48 cap broken");
   property p_es;
      @(posedge clk) disable iff (rst)
      (tick && !period_end && sec_rdi) |=> es_acc == $past(es_acc) + 32'h1;
   endproperty
   a_es: assert property (p_es) else $error("errored second missed");
   property p_ses;
      @(posedge clk) disable iff (rst)
      (tick && !period_end && !sec_severe) |=> ses_acc == $past(ses_acc);
   endproperty
   a_ses: assert property (p_ses) else $error("bad severe second");
   property p_fc;
      @(posedge clk) disable iff (rst)
      (rfi_failure && rfi_prev && !period_end) |=> fc_acc == $past(fc_acc);
   endproperty
   a_fc: assert property (p_fc) else $error("event counted twice");
   property p_span;
      @(posedge clk) disable iff (rst)
      (period_end && rfi_prev) |=> fc_acc == 32'h0;
   endproperty
   a_span: assert property (p_span) else $error("event recounted");
   property p_pub;
      @(posedge clk) disable iff (rst)
      period_end |=>
         far_line_severe_second_count == $past(ses_acc) && period_done;
   endproperty
   a_pub: assert property (p_pub) else $error("period not published");
   property p_uas;
      @(posedge clk) disable iff (rst)
      (tick && !period_end && link.unavailable) |=>
         uas_acc == $past(uas_acc) + 32'h1;
   endproperty
   a_uas: assert property (p_uas) else $error("unavailable missed");
   property p_es0;
      @(posedge clk) disable iff (rst)
      (tick && !period_end && sec_errors == 24'h0 && !sec_rdi && !rdi_defect)
         |=> es_acc == $past(es_acc);
   endproperty
   a_es0: assert property (p_es0) else $error("clean second counted");
   property p_sesk;
      @(posedge clk) disable iff (rst)
      (tick && !period_end && sec_errors >= severe_threshold) |=>
         ses_acc == $past(ses_acc) + 32'h1;
   endproperty
   a_sesk: assert property (p_sesk) else $error("severe second missed");
   // an indication in the boundary cycle belongs to the new period
   property p_cvnew;
      @(posedge clk) disable iff (rst)
      period_end |=>
         cv_acc == ($past(rei_valid) ? 32'($past(rei_ok)) : 32'h0);
   endproperty
   a_cvnew: assert property (p_cvnew) else $error("period not restarted");
   property p_uas_hold;
      @(posedge clk) disable iff (rst)
      (!tick && !period_end) |=> uas_acc == $past(uas_acc);
   endproperty
   a_uas_hold: assert property (p_uas_hold) else $error("moved off tick");
   c_fc: cover property (@(posedge clk) rfi_failure && !rfi_prev);
   c_ses: cover property (@(posedge clk) tick && sec_severe);
   c_per: cover property (@(posedge clk) period_end && rfi_failure);
endmodule

//--- inc/far_line_pkg.sv
// constants for the far-end line performance monitor
// assumes one system clock; tick and period strobes come from local logic
package far_line_pkg;
   localparam int count_width = 32;
   localparam int rei_width = 8;
   // seconds needed to enter or leave unavailability
   localparam logic [3:0] unavail_run = 4'ha;
   localparam logic [count_width-1:0] count_reset = 32'h0;
   localparam logic [23:0] k_default = 24'h0000c8;
   // slower than OC-48: the indication carries up to 8 x n errors
   localparam int rei_per_sts = 8;
   // OC-48: the indication carries 0 to 255 errors
   localparam logic [7:0] rei_max_oc48 = 8'hff;
endpackage

//--- inc/far_line_if.sv
// per-second verdict passed from the classifier to the availability tracker
// assumes both ends on the same clock
`timescale 1ns/1ns
interface far_line_if;
   logic second_done;
   logic severe;
   logic unavailable;
   modport classifier(output second_done, output severe, input unavailable);
   modport tracker(input second_done, input severe, output unavailable);
endinterface

//--- src/far_line_avail.sv
// availability state of the far-end line, stepped once a second
// assumes second_done is a one-cycle pulse on clk
`timescale 1ns/1ns
module far_line_avail (
   input wire logic clk,
   input wire logic rst,
   far_line_if.tracker link
);
   logic [3:0] run;
   logic unavail;
   assign link.unavailable = unavail;

   // run counts consecutive seconds opposing the present state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run <= 4'h0;
         unavail <= 1'b0;
      end else if (link.second_done) begin
         if (link.severe != unavail) begin
            if (run == far_line_pkg::unavail_run - 4'h1) begin
               unavail <= ~unavail;
               run <= 4'h0;
            end else begin
               run <= run + 4'h1;
            end
         end else begin
            run <= 4'h0;
         end
      end
   end

   property p_enter;
      @(posedge clk) disable iff (rst)
      (!unavail && link.second_done && link.severe && run == 4'h9) |=> unavail;
   endproperty
   a_enter: assert property (p_enter) else $error("not unavailable");
   property p_leave;
      @(posedge clk) disable iff (rst)
      (unavail && link.second_done && !link.severe && run == 4'h9)
         |=> !unavail;
   endproperty
   a_leave: assert property (p_leave) else $error("still unavailable");
   property p_hold;
      @(posedge clk) disable iff (rst)
      !link.second_done |=> $stable(unavail);
   endproperty
   a_hold: assert property (p_hold) else $error("changed off tick");
   c_enter: cover property (@(posedge clk) $rose(unavail));
   c_leave: cover property (@(posedge clk) $fell(unavail));
endmodule

//--- testbench/far_lte_model.sv
// far-end line terminating equipment: sends line overhead indications
// assumes the bench calls its tasks; outputs change at falling clk
`timescale 1ns/1ns
module far_line_term_model (
   input wire logic clk,
   output logic rei_valid,
   output logic [10:0] rei_count,
   output logic rdi_defect,
   output logic rfi_failure
);
   initial begin
      rei_valid = 1'b0;
      rei_count = 11'h7ff;
      rdi_defect = 1'b0;
      rfi_failure = 1'b0;
   end
   // idle count is inverted so unqualified sampling of it shows up
   task automatic send_rei(input logic [10:0] c);
      @(negedge clk);
      rei_valid = 1'b1;
      rei_count = c;
      @(negedge clk);
      rei_valid = 1'b0;
      rei_count = ~c;
   endtask
   task automatic lvl(input logic rdi, input logic rfi);
      @(negedge clk);
      rdi_defect = rdi;
      rfi_failure = rfi;
   endtask
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the far-end line performance monitor
// assumes the default oc48 build, so reported errors clamp at 255
`timescale 1ns/1ns
module tb_top;
   logic clk, rst, tick, period_end, rei_valid, rdi_defect, rfi_failure;
   logic [10:0] rei_count;
   logic [23:0] k;
   logic [31:0] cv, es, ses, uas, fc;
   logic unavail, done;
   int n_errors = 0;
   int tests_run = 0;
   far_line_term_model far_line_term_model_i (.clk, .rei_valid, .rei_count,
      .rdi_defect, .rfi_failure);
   far_line_perf_monitor far_line_perf_monitor_i (.clk, .rst, .rei_valid,
      .rei_count, .rdi_defect, .rfi_failure, .severe_threshold(k), .tick,
      .period_end, .far_line_coding_violation_count(cv),
      .far_line_errored_second_count(es),
      .far_line_severe_second_count(ses),
      .far_line_unavailable_second_count(uas),
      .far_line_failure_event_count(fc),
      .far_line_unavailable(unavail), .period_done(done));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic secs(input int n);
      repeat (n) begin
         @(negedge clk);
         tick = 1'b1;
         @(negedge clk);
         tick = 1'b0;
      end
   endtask
   // the verdict moves one register behind the tick, so allow slack
   task automatic chk_un(input logic exp);
      repeat (4) @(negedge clk);
      chk({31'h0, unavail}, {31'h0, exp});
   endtask
   task automatic close;
      @(negedge clk);
      period_end = 1'b1;
      @(negedge clk);
      period_end = 1'b0;
      chk({31'h0, done}, 32'h1);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic t_cv;
      far_line_term_model_i.send_rei(11'h005);
      far_line_term_model_i.send_rei(11'h12c);
      secs(1);
      close;
      chk(cv, 32'h104);
      chk(es, 32'h1);
      chk(ses, 32'h1);
      $display("test cv done");
   endtask
   // one light second, one rdi second, one clean, one exactly at K
   task automatic t_rdi;
      far_line_term_model_i.send_rei(11'h003);
      secs(1);
      // the defect stands only in the tick cycle, so it ends one second
      far_line_term_model_i.lvl(1'b1, 1'b0);
      tick = 1'b1;
      far_line_term_model_i.lvl(1'b0, 1'b0);
      tick = 1'b0;
      secs(1);
      far_line_term_model_i.send_rei(11'h064);
      secs(1);
      close;
      chk(cv, 32'h67);
      chk(es, 32'h3);
      chk(ses, 32'h2);
      $display("test rdi done");
   endtask
   task automatic t_uas;
      // a clean second first, so earlier severe seconds do not chain on
      secs(1);
      far_line_term_model_i.lvl(1'b1, 1'b0);
      secs(9);
      chk_un(1'b0);
      secs(1);
      chk_un(1'b1);
      secs(2);
      close;
      chk(uas, 32'h2);
      chk(ses, 32'hc);
      far_line_term_model_i.lvl(1'b0, 1'b0);
      // the second in which the defect drops is still severe
      secs(10);
      chk_un(1'b1);
      secs(1);
      chk_un(1'b0);
      close;
      chk(uas, 32'hb);
      chk(ses, 32'h1);
      $display("test uas done");
   endtask
   task automatic t_fc;
      far_line_term_model_i.lvl(1'b0, 1'b1);
      close;
      chk(fc, 32'h1);
      far_line_term_model_i.lvl(1'b0, 1'b0);
      close;
      chk(fc, 32'h0);
      far_line_term_model_i.lvl(1'b0, 1'b1);
      far_line_term_model_i.lvl(1'b0, 1'b0);
      far_line_term_model_i.lvl(1'b0, 1'b1);
      far_line_term_model_i.lvl(1'b0, 1'b0);
      close;
      chk(fc, 32'h2);
      $display("test fc done");
   endtask
   initial begin
      #200000;
      n_errors++;
      end_sim;
   end
   initial begin
      rst = 1'b1;
      tick = 1'b0;
      period_end = 1'b0;
      k = 24'h000064;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      t_cv;
      t_rdi;
      t_uas;
      t_fc;
      end_sim;
   end
endmodule
